// ==== src/master_reset_consts.svh ====
// Constants for the master reset relay: widths and reset values.
// Assumes inclusion by bare name from the package and design files.
`ifndef MASTER_RESET_CONSTS_SVH
`define MASTER_RESET_CONSTS_SVH
`define OUTPUT_COUNT 8
`define MARKER_COUNT 16
`define OUTPUT_RESET_VALUE 8'h00
`define MARKER_RESET_VALUE 16'h0000
`define REG_COIL_CTRL 4'h0
`define REG_COIL_STATUS 4'h4
`define REG_OUTPUT_STATE 4'h8
`define REG_MARKER_STATE 4'hc
`endif

// ==== src/master_reset_pkg.sv ====
// Types shared by the master reset relay modules.
// Assumes the constants header is on the include path.
`include "master_reset_consts.svh"
package master_reset_pkg;
   typedef logic [`OUTPUT_COUNT-1:0] output_bank_t;
   typedef logic [`MARKER_COUNT-1:0] marker_bank_t;
   typedef struct packed {
      logic output_reset_block;
      logic marker_reset_block;
      logic combined_reset_block;
   } reset_coils_s;
   typedef struct packed {
      output_bank_t local_outputs;
      output_bank_t expansion_outputs;
      marker_bank_t first_marker_range;
      marker_bank_t second_marker_range;
   } image_s;
   typedef enum logic [0:0] {
      bus_idle = 1'b0,
      bus_done = 1'b1
   } bus_state_e;
endpackage

// ==== src/master_reset_relay.sv ====
// Functional notes
// - Output reset clears all local and expansion outputs.
// - Marker reset clears both marker ranges only.
// - Combined reset clears outputs and both marker ranges.
// - Clearing acts on rising edge and while high.
// - Coil effect independent of driving rung.
// - Reset clearing beats every set or write.
// - Each contact shows its own coil state.
//
// Top of the master reset relay: commits the scan image each cycle.
// Assumes the ladder logic presents its rung results every clock and that
// software observes and drives the coils over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "master_reset_consts.svh"
module master_reset_relay (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire master_reset_pkg::image_s rung_image,
   input wire logic [2:0] rung_coils,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output master_reset_pkg::image_s committed_image,
   output master_reset_pkg::reset_coils_s contacts
);
   import master_reset_pkg::*;

   reset_coils_s sw_coils;
   reset_coils_s coils;
   image_s cleared_image;
   logic clear_outputs;
   logic clear_markers;
   bus_state_e bus_state;
   bus_state_e next_bus_state;
   logic [31:0] next_readdata;
   logic bus_req;
   logic take_access;
   logic wr_ctrl;

   // Coils from any rung and from software are ORed into one level, so a
   // rising edge is simply the first cycle of that level.
   assign coils = reset_coils_s'(rung_coils) | sw_coils;

   reset_clear_stage u_clear (
      .scan_image(rung_image),
      .coils(coils),
      .clear_outputs(clear_outputs),
      .clear_markers(clear_markers),
      .cleared_image(cleared_image)
   );

   // Bus answers one cycle after the request is first seen; a write lands
   // on the edge at which the master sees waitrequest low.
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic [31:0] output_word;
   logic [31:0] marker_word;

   assign bus_req = avs_read | avs_write;
   assign take_access = bus_req & (bus_state == bus_idle);
   assign wr_ctrl = avs_write & (bus_state == bus_done) &
                    (avs_address == `REG_COIL_CTRL);
   assign next_bus_state = take_access ? bus_done : bus_idle;

   // The register words are named wires so that the read select sees
   // every change of the state it returns, not only address changes.
   assign ctrl_word = {29'h0, sw_coils};
   assign status_word = {29'h0, contacts};
   assign output_word = {16'h0, committed_image.local_outputs,
                         committed_image.expansion_outputs};
   assign marker_word = {committed_image.first_marker_range,
                         committed_image.second_marker_range};

   function automatic logic [31:0] read_mux(
      input logic [3:0] addr,
      input logic [31:0] ctrl,
      input logic [31:0] status,
      input logic [31:0] outs,
      input logic [31:0] marks
   );
      case (addr)
         `REG_COIL_CTRL: read_mux = ctrl;
         `REG_COIL_STATUS: read_mux = status;
         `REG_OUTPUT_STATE: read_mux = outs;
         `REG_MARKER_STATE: read_mux = marks;
         default: read_mux = 32'h0;
      endcase
   endfunction

   assign next_readdata = (take_access & avs_read) ?
      read_mux(avs_address, ctrl_word, status_word, output_word,
               marker_word) :
      avs_readdata;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= bus_idle;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         sw_coils <= '0;
      end else begin
         bus_state <= next_bus_state;
         avs_waitrequest <= ~take_access;
         avs_readdata <= next_readdata;
         if (wr_ctrl) begin
            sw_coils <= reset_coils_s'(avs_writedata[2:0]);
         end
      end
   end

   // Commit the cleared image; clearing was applied after the rungs.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         committed_image <= '0;
         contacts <= '0;
      end else begin
         committed_image <= cleared_image;
         contacts <= coils;
      end
   end

   a_output_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (coils.output_reset_block | coils.combined_reset_block) |=>
      (committed_image.local_outputs == 8'h00 &&
       committed_image.expansion_outputs == 8'h00))
      else $error("outputs not cleared by output reset");

   a_output_keep: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (coils.output_reset_block & ~coils.marker_reset_block &
       ~coils.combined_reset_block) |=>
      (committed_image.first_marker_range ==
       $past(rung_image.first_marker_range) &&
       committed_image.second_marker_range ==
       $past(rung_image.second_marker_range)))
      else $error("output reset touched the markers");

   a_marker_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (coils.marker_reset_block & ~coils.output_reset_block &
       ~coils.combined_reset_block) |=>
      (committed_image.first_marker_range == 16'h0000 &&
       committed_image.second_marker_range == 16'h0000 &&
       committed_image.local_outputs == $past(rung_image.local_outputs)))
      else $error("marker reset wrong");

   a_marker_keep: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (coils.marker_reset_block & ~coils.output_reset_block &
       ~coils.combined_reset_block) |=>
      (committed_image.expansion_outputs ==
       $past(rung_image.expansion_outputs)))
      else $error("marker reset touched the expansion outputs");

   a_combined_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      coils.combined_reset_block |=> (committed_image == '0))
      else $error("combined reset left bits set");

   a_rise_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(coils.output_reset_block) |=>
      (committed_image.local_outputs == 8'h00 &&
       committed_image.expansion_outputs == 8'h00))
      else $error("rising coil edge did not clear the outputs");

   a_level_hold: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      coils.output_reset_block [*3] |=>
      (committed_image.local_outputs == 8'h00))
      else $error("held coil did not keep outputs cleared");

   a_rung_coil: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rung_coils[1] |=> (committed_image.first_marker_range == 16'h0000))
      else $error("rung coil had no effect");

   a_rung_coil_out: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rung_coils[2] |=> (committed_image.expansion_outputs == 8'h00))
      else $error("rung output coil had no effect");

   a_reset_wins: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (clear_outputs && rung_image.local_outputs != 8'h00) |=>
      (committed_image.local_outputs == 8'h00))
      else $error("set beat the reset");

   a_marker_wins: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (clear_markers && rung_image.second_marker_range != 16'h0000) |=>
      (committed_image.second_marker_range == 16'h0000))
      else $error("marker set beat the reset");

   a_contact_follow: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ##1 (contacts == $past(coils)))
      else $error("contact does not follow coil");

   a_status_read: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (take_access && avs_read && avs_address == `REG_COIL_STATUS) |=>
      (avs_readdata == {29'h0, $past(contacts)}))
      else $error("status read does not show the contacts");

   a_pass_through: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (!clear_outputs && !clear_markers) |=>
      (committed_image == $past(rung_image)))
      else $error("image altered without reset");

   // Bus checks: one answer per request, one cycle long, and only the
   // coil register takes writes.
   a_bus_answer: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (bus_req && avs_waitrequest && bus_state == bus_idle) |=>
      !avs_waitrequest)
      else $error("bus answer late");

   a_wait_pulse: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_ctrl_write: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_write && !avs_waitrequest &&
       avs_address == `REG_COIL_CTRL) |=>
      (sw_coils == reset_coils_s'($past(avs_writedata[2:0]))))
      else $error("coil register write lost");

   a_write_refused: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_write && bus_state == bus_done &&
       avs_address != `REG_COIL_CTRL) |=> $stable(sw_coils))
      else $error("write to a read-only offset changed the coils");
endmodule
`default_nettype wire

// ==== src/reset_clear_stage.sv ====
// Final stage of the scan: applies reset coil clearing to the image.
// Assumes the scan image arrives after all rungs were evaluated.
`timescale 1ns/1ps
`default_nettype none
`include "master_reset_consts.svh"
module reset_clear_stage (
   input wire master_reset_pkg::image_s scan_image,
   input wire master_reset_pkg::reset_coils_s coils,
   output logic clear_outputs,
   output logic clear_markers,
   output master_reset_pkg::image_s cleared_image
);
   import master_reset_pkg::*;
   // The combined block clears both groups; set and latch results lose.
   assign clear_outputs = coils.output_reset_block |
                          coils.combined_reset_block;
   assign clear_markers = coils.marker_reset_block |
                          coils.combined_reset_block;
   always_comb begin
      cleared_image = scan_image;
      if (clear_outputs) begin
         cleared_image.local_outputs = `OUTPUT_RESET_VALUE;
         cleared_image.expansion_outputs = `OUTPUT_RESET_VALUE;
      end
      if (clear_markers) begin
         cleared_image.first_marker_range = `MARKER_RESET_VALUE;
         cleared_image.second_marker_range = `MARKER_RESET_VALUE;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/ladder_model.sv ====
// Model of the user ladder circuit: two rungs may drive each reset coil.
// Assumes the bench changes rung requests just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ladder_model (
   input wire logic ref_clk,
   input wire master_reset_pkg::image_s image_req,
   input wire logic [2:0] rung_a,
   input wire logic [2:0] rung_b,
   output master_reset_pkg::image_s rung_image,
   output logic [2:0] rung_coils
);
   import master_reset_pkg::*;
   // Rung results settle once per scan, as a registered stage.
   always_ff @(posedge ref_clk) begin
      rung_image <= image_req;
      rung_coils <= rung_a | rung_b;
   end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the master reset relay.
// Assumes the ladder model drives rung results and coils each scan.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import master_reset_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   image_s img = '0;
   image_s rung_image, committed_image;
   logic [2:0] ra = 3'h0, rb = 3'h0, rung_coils;
   reset_coils_s contacts;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0, wr = 1'b0, wreq;
   logic [31:0] wd = 32'h0, rdat, q;
   int fails = 0, n_compared = 0;
   localparam image_s PAT = 48'ha5c3_3cf0_0ff0;
   always #20 ref_clk = ~ref_clk;
   ladder_model lm (.ref_clk(ref_clk), .image_req(img), .rung_a(ra),
      .rung_b(rb), .rung_image(rung_image), .rung_coils(rung_coils));
   master_reset_relay uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .rung_image(rung_image), .rung_coils(rung_coils),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .committed_image(committed_image), .contacts(contacts));
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic image_s cleared(image_s i, logic [2:0] c);
      image_s e;
      e = i;
      if (c[2] | c[0]) begin
         e.local_outputs = '0;
         e.expansion_outputs = '0;
      end
      if (c[1] | c[0]) begin
         e.first_marker_range = '0;
         e.second_marker_range = '0;
      end
      return e;
   endfunction
   task automatic drive(image_s i, logic [2:0] a, logic [2:0] b);
      img <= i;
      ra <= a;
      rb <= b;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         fails++;
         print_verdict();
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic test_coils();
      for (int c = 0; c < 8; c++) begin
         drive(PAT, c[2:0], 3'h0);
         chk(committed_image, cleared(PAT, c[2:0]));
         chk(contacts, c[2:0]);
         drive(PAT, 3'h0, c[2:0]);
         chk(committed_image, cleared(PAT, c[2:0]));
         chk(contacts, c[2:0]);
      end
      $display("coil codes done");
   endtask
   task automatic test_bus();
      drive(PAT, 3'h0, 3'h0);
      bus(1'b1, 4'h0, 32'hffff_fff9);
      @(posedge ref_clk);
      chk(committed_image, 48'h0);
      bus(1'b0, 4'h4, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, 4'h8, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      chk(q, 32'h0000_a5c3);
      bus(1'b0, 4'hc, 32'h0);
      chk(q, 32'h3cf0_0ff0);
      bus(1'b1, 4'h2, 32'h7);
      bus(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 4'h4, 32'h0);
      chk(q, 32'h0);
      $display("register bus done");
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      chk(wreq, 1'b1);
      chk(committed_image, 48'h0);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      test_coils();
      test_bus();
      print_verdict();
   end
endmodule
`default_nettype wire
